/* File: aie_pkg.sv */
// constants shared by the add-instruction execute block
// Contract
// RULE1: destination zero writes sum into working register
// RULE2: destination one writes sum back to file
// RULE3: access zero, basic set uses access bank
// RULE4: access one uses bank select register bank
// RULE5: extended set, low address uses indexed offset; the code does so only with access zero, access one stays banked
// RULE6: literal add to accumulator; one cycle; flags
package aie_pkg;
  // opcode fields
  localparam logic [7:0] OPC_ADD_LITERAL = 8'h0F;
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  // access bank split and indexed window
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // status bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_NEGATIVE = 4;
  // reset values
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  typedef enum logic {AIE_IDLE, AIE_EXEC} aie_state_t;
endpackage

/* File: aie_alu_if.sv */
// operands, sum and flags between the sequencer and the adder
`timescale 1ns/1ps
`default_nettype none
interface aie_alu_if;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [7:0] sum;
  logic [4:0] flags;
  modport calc (input op_a, input op_b, output sum, output flags);
  modport user (output op_a, output op_b, input sum, input flags);
endinterface
`default_nettype wire

/* File: aie_adder.sv */
// eight-bit adder with negative, overflow, zero, digit-carry and carry flags
`timescale 1ns/1ps
`default_nettype none
module aie_adder
  import aie_pkg::*;
(
  aie_alu_if.calc alu
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  always_comb
  begin
    low_sum = {1'b0, alu.op_a[3:0]} + {1'b0, alu.op_b[3:0]};
    full_sum = {1'b0, alu.op_a} + {1'b0, alu.op_b};
    alu.sum = full_sum[7:0];
    alu.flags = STATUS_RESET;
    alu.flags[FLAG_CARRY] = full_sum[8]; // see RULE6
    alu.flags[FLAG_DIGIT_CARRY] = low_sum[4]; // see RULE6
    alu.flags[FLAG_ZERO] = (full_sum[7:0] == 8'h00); // see RULE6
    // signed overflow: like-signed operands giving a differently signed sum
    alu.flags[FLAG_OVERFLOW] = (alu.op_a[7] == alu.op_b[7]) && (full_sum[7] != alu.op_a[7]);
    alu.flags[FLAG_NEGATIVE] = full_sum[7]; // see RULE6
  end
endmodule
`default_nettype wire

/* File: aie_execute.sv */
// sequencer for the literal add and the file add instructions
`timescale 1ns/1ps
`default_nettype none
module aie_execute
  import aie_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // instruction issue
  input wire logic INSTR_VALID_IN,
  input wire logic [15:0] INSTR_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  // working register preload
  input wire logic W_LOAD_IN,
  input wire logic [7:0] W_LOAD_DATA_IN,
  // addressing context
  input wire logic EXT_SET_EN_IN,
  input wire logic [3:0] BANK_SELECT_IN,
  input wire logic [11:0] INDEX_BASE_IN,
  // data memory
  output logic [11:0] MEM_ADDR_OUT,
  output logic MEM_RE_OUT,
  input wire logic [7:0] MEM_RDATA_IN,
  output logic MEM_WE_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  // architectural state
  output logic [7:0] W_OUT,
  output logic [4:0] STATUS_OUT
);
  import aie_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  aie_state_t state;
  aie_state_t next_state;
  logic is_file;
  logic next_is_file;
  logic dest_file;
  logic next_dest_file;
  logic [7:0] literal;
  logic [7:0] next_literal;
  logic [11:0] mem_addr;
  logic [11:0] next_mem_addr;
  logic mem_re;
  logic next_mem_re;
  logic mem_we;
  logic next_mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] next_mem_wdata;
  logic [7:0] working_register;
  logic [7:0] next_working_register;
  logic [4:0] status;
  logic [4:0] next_status;
  logic done;
  logic next_done;
  logic busy;
  logic next_busy;
  logic accept;
  logic take_literal;
  logic take_file;
  logic [7:0] file_address;

  aie_alu_if alu ();

  aie_adder u_adder (
    .alu (alu)
  );

  assign file_address = INSTR_IN[7:0];
  assign take_literal = INSTR_IN[15:8] == OPC_ADD_LITERAL;
  assign take_file = INSTR_IN[15:10] == OPC_ADD_FILE;
  // unknown opcodes are dropped without occupying the block
  assign accept = (state == AIE_IDLE) && INSTR_VALID_IN && (take_literal || take_file);
  assign alu.op_a = working_register;
  assign alu.op_b = is_file ? MEM_RDATA_IN : literal;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_is_file = is_file;
    next_dest_file = dest_file;
    next_literal = literal;
    next_mem_addr = mem_addr;
    next_mem_re = 1'b0;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_working_register = working_register;
    next_status = status;
    next_done = 1'b0;
    next_busy = 1'b0;
    case (state)
      AIE_IDLE:
      begin
        if (accept)
        begin
          next_state = AIE_EXEC;
          next_busy = 1'b1;
          next_is_file = take_file;
          next_dest_file = INSTR_IN[DEST_BIT];
          next_literal = file_address;
          next_mem_re = take_file;
          if (INSTR_IN[ACCESS_BIT])
          begin
            next_mem_addr = {BANK_SELECT_IN, file_address}; // see RULE4
          end
          else if (EXT_SET_EN_IN && (file_address <= INDEX_LIMIT))
          begin
            next_mem_addr = 12'(INDEX_BASE_IN + {4'h0, file_address}); // see RULE5
          end
          else if (file_address < ACCESS_SPLIT)
          begin
            next_mem_addr = {ACCESS_LOW_BANK, file_address}; // see RULE3
          end
          else
          begin
            next_mem_addr = {ACCESS_HIGH_BANK, file_address}; // see RULE3
          end
        end
        else if (W_LOAD_IN)
        begin
          next_working_register = W_LOAD_DATA_IN;
        end
      end
      AIE_EXEC:
      begin
        next_state = AIE_IDLE;
        next_done = 1'b1; // see RULE6
        next_status = alu.flags; // see RULE6
        if (is_file && dest_file)
        begin
          next_mem_we = 1'b1; // see RULE2
          next_mem_wdata = alu.sum; // see RULE2
        end
        else
        begin
          next_working_register = alu.sum; // see RULE1
        end
      end
      default:
      begin
        next_state = AIE_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state <= AIE_IDLE;
      is_file <= 1'b0;
      dest_file <= 1'b0;
      literal <= 8'h00;
      mem_addr <= ADDR_RESET;
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      working_register <= WORK_RESET;
      status <= STATUS_RESET;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      is_file <= next_is_file;
      dest_file <= next_dest_file;
      literal <= next_literal;
      mem_addr <= next_mem_addr;
      mem_re <= next_mem_re;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      working_register <= next_working_register;
      status <= next_status;
      done <= next_done;
      busy <= next_busy;
    end
  end

  // busy has its own flop so the pin carries no decode logic
  assign BUSY_OUT = busy;
  assign DONE_OUT = done;
  assign MEM_ADDR_OUT = mem_addr;
  assign MEM_RE_OUT = mem_re;
  assign MEM_WE_OUT = mem_we;
  assign MEM_WDATA_OUT = mem_wdata;
  assign W_OUT = working_register;
  assign STATUS_OUT = status;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  AST_FILE_TO_W: assert property ( // see RULE1
    (BUSY_OUT && is_file && !dest_file)
    |=> (W_OUT == 8'($past(W_OUT) + $past(MEM_RDATA_IN))) && !MEM_WE_OUT)
    else $error("file add to working register gave a wrong value");

  AST_FILE_TO_FILE: assert property ( // see RULE2
    (BUSY_OUT && is_file && dest_file)
    |=> MEM_WE_OUT && (MEM_WDATA_OUT == 8'($past(W_OUT) + $past(MEM_RDATA_IN)))
        && $stable(W_OUT))
    else $error("file add write-back gave a wrong value");

  AST_ACCESS_BANK: assert property ( // see RULE3
    (accept && take_file && !INSTR_IN[ACCESS_BIT] && !EXT_SET_EN_IN)
    |=> MEM_RE_OUT && (MEM_ADDR_OUT[7:0] == $past(INSTR_IN[7:0]))
        && (MEM_ADDR_OUT[11:8] == ($past(INSTR_IN[7:0]) < 8'h60 ? 4'h0 : 4'hF)))
    else $error("access bank address is wrong");

  AST_BANKED: assert property ( // see RULE4
    (accept && take_file && INSTR_IN[ACCESS_BIT])
    |=> MEM_ADDR_OUT == {$past(BANK_SELECT_IN), $past(INSTR_IN[7:0])})
    else $error("banked address is wrong");

  AST_INDEXED: assert property ( // see RULE5
    (accept && take_file && !INSTR_IN[ACCESS_BIT] && EXT_SET_EN_IN && INSTR_IN[7:0] <= 8'h5F)
    |=> MEM_ADDR_OUT == 12'($past(INDEX_BASE_IN) + {4'h0, $past(INSTR_IN[7:0])}))
    else $error("indexed offset address is wrong");

  AST_LITERAL: assert property ( // see RULE6
    (accept && take_literal)
    |=> BUSY_OUT ##1 (DONE_OUT && !BUSY_OUT
        && W_OUT == 8'($past(W_OUT, 2) + $past(INSTR_IN[7:0], 2))
        && STATUS_OUT[0] == ({1'b0, $past(W_OUT, 2)} + {1'b0, $past(INSTR_IN[7:0], 2)} > 9'h0FF)))
    else $error("literal add result or timing is wrong");

endmodule
`default_nettype wire

/* File: tb_add_instruction_execute.sv */
// self-checking bench for the add-instruction execute block
`timescale 1ns/1ps
`default_nettype none
module tb_add_instruction_execute;
  import aie_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic wld = 1'b0;
  logic [7:0] wd = 8'h00;
  logic ext = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [11:0] base = 12'h000;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] rdata;
  logic busy, done, re, we;
  logic [11:0] addr;
  logic [7:0] wdata, w;
  logic [4:0] st;
  logic [7:0] w_m = 8'h00;
  int mismatches = 0;
  int compares = 0;
  always #4 clk = ~clk;
  // memory stops showing the old byte once the read strobe is gone
  assign rdata = re ? rd_val : ~rd_val;
  aie_execute u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_IN(ins),
    .BUSY_OUT(busy), .DONE_OUT(done), .W_LOAD_IN(wld), .W_LOAD_DATA_IN(wd),
    .EXT_SET_EN_IN(ext), .BANK_SELECT_IN(bank), .INDEX_BASE_IN(base), .MEM_ADDR_OUT(addr),
    .MEM_RE_OUT(re), .MEM_RDATA_IN(rdata), .MEM_WE_OUT(we), .MEM_WDATA_OUT(wdata),
    .W_OUT(w), .STATUS_OUT(st));
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] flg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, lo[4], s[8]};
  endfunction
  function automatic logic [15:0] fil(input logic d, input logic a, input logic [7:0] f);
    return {OPC_ADD_FILE, d, a, f};
  endfunction
  // inputs change at the falling edge; one issue per two cycles, back to back
  task automatic do_op(input logic [15:0] word, input logic [7:0] opnd, input logic [11:0] ea);
    logic f;
    logic wr;
    logic [4:0] fl;
    logic [7:0] sum;
    f = (word[15:10] == OPC_ADD_FILE);
    wr = f && word[DEST_BIT];
    fl = flg(w_m, opnd);
    sum = w_m + opnd;
    rd_val = opnd;
    vld = 1'b1;
    ins = word;
    @(negedge clk);
    vld = 1'b0;
    chk(busy, 1'b1);
    chk(re, f);
    if (f)
      chk(addr, ea);
    @(negedge clk);
    chk(done, 1'b1);
    chk(we, wr);
    if (wr)
      chk(wdata, sum);
    else
      w_m = sum;
    chk(w, w_m);
    chk(st, fl);
  endtask
  task automatic preload(input logic [7:0] v);
    wld = 1'b1;
    wd = v;
    @(negedge clk);
    wld = 1'b0;
    w_m = v;
    chk(w, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({busy, done, re, we, st}, 16'h0000);
    chk(addr, 16'h0000);
    chk({wdata, w}, 16'h0000);
  endtask
  task automatic t_literal;
    logic [7:0] tab [8] = '{8'h10, 8'h15, 8'h80, 8'h80, 8'h08, 8'h08, 8'h7F, 8'h01};
    for (int i = 0; i < 8; i += 2)
    begin
      preload(tab[i]);
      do_op({OPC_ADD_LITERAL, tab[i+1]}, tab[i+1], 12'h000);
    end
    do_op({OPC_ADD_LITERAL, 8'hFF}, 8'hFF, 12'h000);
  endtask
  task automatic t_banked;
    bank = 4'h3;
    preload(8'h17);
    do_op(fil(1'b0, 1'b1, 8'h22), 8'hC2, 12'h322);
    do_op(fil(1'b1, 1'b1, 8'hFF), 8'h40, 12'h3FF);
  endtask
  task automatic t_access;
    ext = 1'b0;
    do_op(fil(1'b0, 1'b0, 8'h22), 8'h01, {ACCESS_LOW_BANK, 8'h22});
    do_op(fil(1'b1, 1'b0, 8'h5F), 8'h9C, {ACCESS_LOW_BANK, 8'h5F});
    do_op(fil(1'b0, 1'b0, 8'h80), 8'hF0, {ACCESS_HIGH_BANK, 8'h80});
  endtask
  task automatic t_indexed;
    ext = 1'b1;
    base = 12'hA10;
    do_op(fil(1'b0, 1'b0, 8'h5F), 8'h33, 12'hA6F);
    do_op(fil(1'b1, 1'b0, 8'h00), 8'h0A, 12'hA10);
    do_op(fil(1'b0, 1'b0, 8'h60), 8'h11, {ACCESS_HIGH_BANK, 8'h60});
    base = 12'hFF0;
    do_op(fil(1'b1, 1'b0, 8'h20), 8'h05, 12'h010);
    do_op(fil(1'b0, 1'b1, 8'h10), 8'h21, {bank, 8'h10});
  endtask
  // a second word while busy, a preload beside an issue and a near-miss opcode are all ignored
  task automatic t_refuse;
    logic [4:0] fl;
    fl = flg(w_m, 8'h01);
    vld = 1'b1;
    ins = {OPC_ADD_LITERAL, 8'h01};
    wld = 1'b1;
    wd = 8'hAA;
    @(negedge clk);
    chk(busy, 1'b1);
    ins = {OPC_ADD_LITERAL, 8'h02};
    @(negedge clk);
    vld = 1'b0;
    wld = 1'b0;
    w_m = w_m + 8'h01;
    chk(done, 1'b1);
    chk(w, w_m);
    chk(st, fl);
    @(negedge clk);
    chk({busy, done}, 2'b00);
    chk(w, w_m);
    vld = 1'b1;
    ins = 16'h2255;
    @(negedge clk);
    vld = 1'b0;
    chk({busy, re}, 2'b00);
    chk(w, w_m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_literal();
    t_banked();
    t_access();
    t_indexed();
    t_refuse();
    end_of_test();
  end
  // the tests need well under a hundred cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
